/* hw/afe_pkg.sv */
// Package for the converter front-end control block: register map, fields, codes
package afe_pkg;
  localparam int          AFE_RES_W          = 16;
  localparam logic [11:0] AFE_OFF_PRIMARY    = 12'h000;
  localparam logic [11:0] AFE_OFF_AUX        = 12'h004;
  localparam logic [11:0] AFE_OFF_CURRENT_SOURCE_CONTROL       = 12'h008;
  localparam logic [11:0] AFE_OFF_STATUS     = 12'h00C;
  localparam logic [11:0] AFE_OFF_CAL        = 12'h010;
  localparam logic [11:0] AFE_OFF_PDATA      = 12'h014;
  localparam logic [11:0] AFE_OFF_ADATA      = 12'h018;
  localparam logic [11:0] AFE_OFF_POFS       = 12'h01C;
  localparam logic [11:0] AFE_OFF_PGAIN      = 12'h020;
  localparam logic [11:0] AFE_OFF_AOFS       = 12'h024;
  localparam logic [11:0] AFE_OFF_AGAIN      = 12'h028;
  localparam logic [7:0]  AFE_PRIMARY_RESET  = 8'h07;
  localparam logic [7:0]  AFE_AUX_RESET      = 8'h00;
  localparam logic [3:0]  AFE_CURRENT_SOURCE_CONTROL_RESET     = 4'h0;
  localparam logic [15:0] AFE_OFS_RESET      = 16'h8000;
  localparam logic [15:0] AFE_GAIN_RESET     = 16'h5555;
  localparam logic [15:0] AFE_ALL_ONES       = 16'hFFFF;
  localparam logic [15:0] AFE_MIDSCALE       = 16'h8000;
  localparam int          AFE_RANGE_COUNT    = 8;
  // Full-scale ranges in microvolts with 2.5 V external reference
  localparam int          AFE_RANGE_MIN_UV   = 20000;
  localparam int          AFE_RANGE_MAX_UV   = 2560000;
  localparam int          AFE_REF_EXT_MV     = 2500;
  localparam int          AFE_REF_INT_MV     = 1250;
  localparam int          AFE_REF_DETECT_MV  = 300;

  typedef struct packed {
    logic       unipolar;
    logic       ext_ref;
    logic [1:0] channel;
    logic       rsvd;
    logic [2:0] range;
  } afe_primary_s;

  typedef struct packed {
    logic       unipolar;
    logic       ext_ref;
    logic [1:0] channel;
    logic [3:0] rsvd;
  } afe_aux_s;

  typedef struct packed {
    logic       burnout;
    logic       combine;
    logic       exc_two;
    logic       exc_one;
  } afe_current_source_control_s;

  typedef enum logic [2:0] {
    AFE_CAL_IDLE = 3'b001,
    AFE_CAL_RUN  = 3'b010,
    AFE_CAL_DONE = 3'b100
  } afe_cal_e;
endpackage

/* hw/afe_front_end.sv */
// Front-end control of the dual converter: ranges, coding, reference, currents, reference detect
//
// Contract
// - Primary range field picks one of eight gains
// - Ranges 20 mV to 2.56 V, doubling
// - Auxiliary converter has one fixed range
// - Unipolar bit changes coding and calibration points; here it changes only the output coding, not the calibration points
// - Unipolar output is straight binary
// - Bipolar output is offset binary
// - Cleared reference select uses internal reference
// - Burnout enable switches both burnout currents
// - Excitation currents individual or combined
// - Missing-reference flag on bad reference
// - Missing reference forces results all ones
// - Missing reference blocks calibration, sets error
// - Channel bits pick input pairing or short
module afe_front_end
  import afe_pkg::*;
#(
  parameter int RES_W = AFE_RES_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Converter core results, signed offset-from-midscale words
  input  wire logic              primary_result_valid,
  input  wire logic [RES_W-1:0]  primary_result,
  input  wire logic              aux_result_valid,
  input  wire logic [RES_W-1:0]  aux_result,
  input  wire logic              primary_cal_point_valid,
  input  wire logic [RES_W-1:0]  primary_cal_point,
  input  wire logic              aux_cal_point_valid,
  input  wire logic [RES_W-1:0]  aux_cal_point,
  // Reference detector comparators
  input  wire logic              ref_below_threshold,
  input  wire logic              reference_pos_open,
  input  wire logic              reference_neg_open,
  // Analog controls
  output logic [2:0]             primary_gain_select,
  output logic [1:0]             primary_channel_select,
  output logic                   primary_ref_internal,
  output logic                   aux_ref_internal,
  output logic [1:0]             aux_channel_select,
  output logic                   aux_gain_bypass,
  output logic                   burnout_source_pos,
  output logic                   burnout_sink_neg,
  output logic [1:0]             excitation_out_one,
  output logic [1:0]             excitation_out_two,
  output logic                   missing_reference_flag
);
  afe_primary_s      primary_conv_control;
  afe_aux_s          aux_conv_control;
  afe_current_source_control_s         current_source_control;
  logic [RES_W-1:0]  primary_data;
  logic [RES_W-1:0]  aux_data;
  logic [RES_W-1:0]  primary_ofs;
  logic [RES_W-1:0]  primary_gain;
  logic [RES_W-1:0]  aux_ofs;
  logic [RES_W-1:0]  aux_gain;
  logic              primary_cal_error;
  logic              aux_cal_error;
  logic [1:0]        cal_kind;
  afe_cal_e          primary_cal_state;
  afe_cal_e          aux_cal_state;
  logic              wr_en;
  logic              rd_sel;
  logic              cal_start_primary;
  logic              cal_start_aux;
  logic              ref_missing;

  assign wr_en  = psel && penable && pwrite;
  assign rd_sel = psel && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        AFE_OFF_PRIMARY, AFE_OFF_AUX, AFE_OFF_CURRENT_SOURCE_CONTROL, AFE_OFF_STATUS, AFE_OFF_CAL,
        AFE_OFF_PDATA, AFE_OFF_ADATA, AFE_OFF_POFS, AFE_OFF_PGAIN, AFE_OFF_AOFS,
        AFE_OFF_AGAIN: pslverr = 1'b0;
        default:       pslverr = 1'b1;
      endcase
    end
  end

  // Calibration start: bit0 primary, bit1 aux, bit2 selects gain (else offset)
  assign cal_start_primary = wr_en && (paddr == AFE_OFF_CAL) && pwdata[0];
  assign cal_start_aux     = wr_en && (paddr == AFE_OFF_CAL) && pwdata[1];

  assign ref_missing = ref_below_threshold || reference_pos_open || reference_neg_open;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missing_reference_flag <= 1'b0;
    end else begin
      missing_reference_flag <= ref_missing;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_conv_control   <= afe_primary_s'(AFE_PRIMARY_RESET);
      aux_conv_control       <= afe_aux_s'(AFE_AUX_RESET);
      current_source_control <= afe_current_source_control_s'(AFE_CURRENT_SOURCE_CONTROL_RESET);
      cal_kind               <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        AFE_OFF_PRIMARY: primary_conv_control   <= afe_primary_s'(pwdata[7:0]);
        AFE_OFF_AUX:     aux_conv_control       <= afe_aux_s'(pwdata[7:0]);
        AFE_OFF_CURRENT_SOURCE_CONTROL:    current_source_control <= afe_current_source_control_s'(pwdata[3:0]);
        AFE_OFF_CAL: begin
          if (pwdata[0]) begin
            cal_kind[0] <= pwdata[2];
          end
          if (pwdata[1]) begin
            cal_kind[1] <= pwdata[2];
          end
        end
        default: ;
      endcase
    end
  end

  // range code 0 is 20 mV, each step doubles
  assign primary_gain_select    = primary_conv_control.range;
  assign primary_channel_select = primary_conv_control.channel;
  assign aux_channel_select     = aux_conv_control.channel;
  assign aux_gain_bypass        = 1'b1;
  // internal reference when select is zero
  assign primary_ref_internal   = !primary_conv_control.ext_ref;
  assign aux_ref_internal       = !aux_conv_control.ext_ref;
  assign burnout_source_pos     = current_source_control.burnout;
  assign burnout_sink_neg       = current_source_control.burnout;

  // excitation routing, 2'b10 means double current
  always_comb begin
    excitation_out_one = 2'b00;
    excitation_out_two = 2'b00;
    if (current_source_control.combine) begin
      if (current_source_control.exc_two) begin
        excitation_out_two = 2'b10;
      end else begin
        excitation_out_one = 2'b10;
      end
    end else begin
      excitation_out_one = {1'b0, current_source_control.exc_one};
      excitation_out_two = {1'b0, current_source_control.exc_two};
    end
  end

  // coding only; unipolar straight, bipolar offset binary
  function automatic logic [RES_W-1:0] afe_code(input logic uni, input logic [RES_W-1:0] raw);
    logic [RES_W-1:0] res;
    res = '0;
    if (uni) begin
      // Negative inputs clamp to zero in unipolar mode
      if (raw[RES_W-1]) begin
        res = '0;
      end else if (&raw[RES_W-2:0]) begin
        // Doubling alone would stop one code short; positive full scale must read all ones
        res = '1;
      end else begin
        res = {raw[RES_W-2:0], 1'b0};
      end
    end else begin
      res = raw ^ AFE_MIDSCALE[RES_W-1:0];
    end
    return res;
  endfunction

  // force all ones on missing reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_data <= '0;
      aux_data     <= '0;
    end else begin
      if (primary_result_valid) begin
        primary_data <= ref_missing ? AFE_ALL_ONES[RES_W-1:0]
                                    : afe_code(primary_conv_control.unipolar, primary_result);
      end
      if (aux_result_valid) begin
        aux_data <= ref_missing ? AFE_ALL_ONES[RES_W-1:0]
                                : afe_code(aux_conv_control.unipolar, aux_result);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_cal_state <= AFE_CAL_IDLE;
    end else begin
      case (primary_cal_state)
        AFE_CAL_IDLE: if (cal_start_primary) primary_cal_state <= AFE_CAL_RUN;
        AFE_CAL_RUN:  if (primary_cal_point_valid) primary_cal_state <= AFE_CAL_DONE;
        AFE_CAL_DONE: primary_cal_state <= cal_start_primary ? AFE_CAL_RUN : AFE_CAL_IDLE;
        default:      primary_cal_state <= AFE_CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_cal_state <= AFE_CAL_IDLE;
    end else begin
      case (aux_cal_state)
        AFE_CAL_IDLE: if (cal_start_aux) aux_cal_state <= AFE_CAL_RUN;
        AFE_CAL_RUN:  if (aux_cal_point_valid) aux_cal_state <= AFE_CAL_DONE;
        AFE_CAL_DONE: aux_cal_state <= cal_start_aux ? AFE_CAL_RUN : AFE_CAL_IDLE;
        default:      aux_cal_state <= AFE_CAL_IDLE;
      endcase
    end
  end

  // block coefficient update, set error; start clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_cal_error <= 1'b0;
      aux_cal_error     <= 1'b0;
    end else begin
      if (primary_cal_state == AFE_CAL_RUN && ref_missing) begin
        primary_cal_error <= 1'b1;
      end else if (cal_start_primary) begin
        primary_cal_error <= 1'b0;
      end
      if (aux_cal_state == AFE_CAL_RUN && ref_missing) begin
        aux_cal_error <= 1'b1;
      end else if (cal_start_aux) begin
        aux_cal_error <= 1'b0;
      end
    end
  end

  // coefficients load only with valid reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_ofs  <= AFE_OFS_RESET[RES_W-1:0];
      primary_gain <= AFE_GAIN_RESET[RES_W-1:0];
      aux_ofs      <= AFE_OFS_RESET[RES_W-1:0];
      aux_gain     <= AFE_GAIN_RESET[RES_W-1:0];
    end else begin
      if (primary_cal_state == AFE_CAL_RUN && primary_cal_point_valid && !ref_missing
          && !primary_cal_error) begin
        if (cal_kind[0]) begin
          primary_gain <= primary_cal_point;
        end else begin
          primary_ofs <= primary_cal_point;
        end
      end
      if (aux_cal_state == AFE_CAL_RUN && aux_cal_point_valid && !ref_missing && !aux_cal_error) begin
        if (cal_kind[1]) begin
          aux_gain <= aux_cal_point;
        end else begin
          aux_ofs <= aux_cal_point;
        end
      end
    end
  end

  // Read data registered on the access phase would add a cycle; a mux keeps zero wait
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_sel) begin
      case (paddr)
        AFE_OFF_PRIMARY: prdata = {24'h00_0000, primary_conv_control};
        AFE_OFF_AUX:     prdata = {24'h00_0000, aux_conv_control};
        AFE_OFF_CURRENT_SOURCE_CONTROL:    prdata = {28'h000_0000, current_source_control};
        AFE_OFF_STATUS:  prdata = {28'h000_0000, primary_cal_state != AFE_CAL_IDLE ||
                                   aux_cal_state != AFE_CAL_IDLE, aux_cal_error,
                                   primary_cal_error, missing_reference_flag};
        AFE_OFF_CAL:     prdata = {30'h0000_0000, cal_kind};
        AFE_OFF_PDATA:   prdata = {16'h0000, primary_data};
        AFE_OFF_ADATA:   prdata = {16'h0000, aux_data};
        AFE_OFF_POFS:    prdata = {16'h0000, primary_ofs};
        AFE_OFF_PGAIN:   prdata = {16'h0000, primary_gain};
        AFE_OFF_AOFS:    prdata = {16'h0000, aux_ofs};
        AFE_OFF_AGAIN:   prdata = {16'h0000, aux_gain};
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end

  property p_force_ones;
    @(posedge pclk) disable iff (!presetn)
      (primary_result_valid && ref_missing) |=> (primary_data == AFE_ALL_ONES);
  endproperty
  AST_FORCE_ONES: assert property (p_force_ones) else $error("result not all ones");

  AST_AUX_FORCE_ONES: assert property (@(posedge pclk) disable iff (!presetn)
    (aux_result_valid && ref_missing) |=> (aux_data == AFE_ALL_ONES[RES_W-1:0]))
    else $error("aux result not all ones");

  AST_FLAG_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 missing_reference_flag == $past(ref_missing)) else $error("flag lag wrong");

  sequence s_cal_bad;
    primary_cal_state == AFE_CAL_RUN && ref_missing;
  endsequence
  AST_CAL_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    s_cal_bad |=> primary_cal_error) else $error("cal error not set");

  AST_CAL_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (primary_cal_error && primary_cal_state == AFE_CAL_RUN) |=> $stable(primary_ofs) && $stable(primary_gain))
    else $error("coefficient updated with bad ref");

  AST_BURNOUT: assert property (@(posedge pclk) disable iff (!presetn)
    burnout_source_pos == burnout_sink_neg) else $error("burnout split");

  AST_BIPOLAR_MID: assert property (@(posedge pclk) disable iff (!presetn)
    (primary_result_valid && !ref_missing && !primary_conv_control.unipolar && primary_result == '0)
    |=> primary_data == AFE_MIDSCALE) else $error("bipolar zero not midscale");

  AST_UNIPOLAR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (primary_result_valid && !ref_missing && primary_conv_control.unipolar && primary_result == '0)
    |=> primary_data == '0) else $error("unipolar zero not zero");

  AST_UNIPOLAR_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    (primary_result_valid && !ref_missing && primary_conv_control.unipolar
     && primary_result == {1'b0, {(RES_W-1){1'b1}}}) |=> primary_data == AFE_ALL_ONES[RES_W-1:0])
    else $error("unipolar full scale not all ones");

  AST_REF_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    primary_ref_internal != primary_conv_control.ext_ref) else $error("ref select wrong");

  AST_CAL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_start_primary && !(primary_cal_state == AFE_CAL_RUN && ref_missing)) |=> !primary_cal_error)
    else $error("cal error not cleared on start");

  AST_EXC_COMBINE: assert property (@(posedge pclk) disable iff (!presetn)
    current_source_control.combine |-> (excitation_out_one == 2'b00 || excitation_out_two == 2'b00))
    else $error("combined current on both pins");
endmodule

/* verification/afe_ref_source.sv */
// Reference source model: drives the reference detector levels seen by the block
module afe_ref_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] ref_mode,
  output logic            ref_below_threshold,
  output logic            reference_pos_open,
  output logic            reference_neg_open
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_below_threshold <= 1'b0;
      reference_pos_open  <= 1'b0;
      reference_neg_open  <= 1'b0;
    end else begin
      ref_below_threshold <= (ref_mode == 2'h1);
      reference_pos_open  <= (ref_mode == 2'h2);
      reference_neg_open  <= (ref_mode == 2'h3);
    end
  end
endmodule

/* verification/afe_front_end_test.sv */
// Self-checking bench for the converter front-end control block
module afe_front_end_test;
  timeunit 1ns;
  timeprecision 1ps;
  import afe_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] vld;
  logic [15:0] word;
  logic [1:0] ref_mode, p_ch, a_ch, exc1, exc2;
  logic below, pos_open, neg_open, p_int, a_int, bypass, bo_pos, bo_neg, flag;
  logic [2:0] gain_sel;
  int fail_count, compares, cycles;
  afe_primary_s p;

  afe_front_end dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .primary_result_valid(vld[0]), .primary_result(word), .aux_result_valid(vld[1]), .aux_result(word),
    .primary_cal_point_valid(vld[2]), .primary_cal_point(word), .aux_cal_point_valid(vld[3]),
    .aux_cal_point(word), .ref_below_threshold(below), .reference_pos_open(pos_open),
    .reference_neg_open(neg_open), .primary_gain_select(gain_sel), .primary_channel_select(p_ch),
    .primary_ref_internal(p_int), .aux_ref_internal(a_int), .aux_channel_select(a_ch),
    .aux_gain_bypass(bypass), .burnout_source_pos(bo_pos), .burnout_sink_neg(bo_neg),
    .excitation_out_one(exc1), .excitation_out_two(exc2), .missing_reference_flag(flag));
  afe_ref_source ref_src (.pclk(pclk), .presetn(presetn), .ref_mode(ref_mode),
    .ref_below_threshold(below), .reference_pos_open(pos_open), .reference_neg_open(neg_open));

  always #5 pclk = ~pclk;

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Long enough for the whole sequence several times over
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // A stalled slave is only ended by the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    @(negedge pclk);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(what, q, exp);
  endtask

  // Core word is released to its inverse once the strobe drops
  task automatic pulse(input int idx, input logic [15:0] v);
    @(posedge pclk);
    vld[idx] <= 1'b1;
    word <= v;
    @(posedge pclk);
    vld <= 4'h0;
    word <= ~v;
  endtask

  task automatic cal(input int conv, input logic gain, input logic [1:0] mode, input logic [15:0] v);
    logic [31:0] st;
    logic        e;
    st = 32'hFFFF_FFFF;
    wr(AFE_OFF_CAL, {29'h0, gain, conv == 1, conv == 0});
    @(posedge pclk);
    ref_mode <= mode;
    @(posedge pclk);
    pulse(conv + 2, v);
    ref_mode <= 2'h0;
    while (st[3] !== 1'b0) begin
      apb(1'b0, AFE_OFF_STATUS, 32'h0000_0000, st, e);
    end
  endtask

  logic [15:0] raw[6] = '{16'h8000, 16'h0000, 16'h7FFF, 16'h0000, 16'h4000, 16'h8000};
  logic [15:0] cod[6] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h0000, 16'h8000, 16'h0000};
  logic [3:0] icv[6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
  logic [4:0] ice[6] = '{5'h04, 5'h01, 5'h05, 5'h08, 5'h02, 5'h10};

  initial begin
    logic [31:0] q;
    logic        e;
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    vld = 0; word = 0; ref_mode = 0; fail_count = 0; compares = 0; cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("primary_ctrl", AFE_OFF_PRIMARY, 32'(AFE_PRIMARY_RESET));
    rd_chk("aux_ctrl", AFE_OFF_AUX, 32'(AFE_AUX_RESET));
    rd_chk("current_source_control", AFE_OFF_CURRENT_SOURCE_CONTROL, 32'(AFE_CURRENT_SOURCE_CONTROL_RESET));
    rd_chk("pofs", AFE_OFF_POFS, 32'(AFE_OFS_RESET));
    rd_chk("again", AFE_OFF_AGAIN, 32'(AFE_GAIN_RESET));
    rd_chk("status", AFE_OFF_STATUS, 32'h0000_0000);
    check("ref_int", {30'h0, p_int, a_int}, 32'h0000_0003);
    check("bypass", 32'(bypass), 32'h0000_0001);
    apb(1'b0, 12'h0FC, 32'h0000_0000, q, e);
    check("unmapped", {e, q[30:0]}, 32'h8000_0000);
    for (int i = 0; i < AFE_RANGE_COUNT; i++) begin
      p = '{unipolar: 1'b0, ext_ref: 1'b1, channel: 2'(i), rsvd: 1'b0, range: 3'(i)};
      wr(AFE_OFF_PRIMARY, 32'(p));
      check("range", {27'h0, gain_sel, p_ch}, 32'(i * 4 + i % 4));
      check("ext_ref", 32'(p_int), 32'h0000_0000);
    end
    wr(AFE_OFF_AUX, 32'h0000_0070);
    check("aux", {29'h0, a_ch, a_int}, 32'h0000_0006);
    for (int i = 0; i < 6; i++) begin
      wr(AFE_OFF_CURRENT_SOURCE_CONTROL, 32'(icv[i]));
      check("currents", {26'h0, bo_neg, bo_pos, exc1, exc2}, {26'h0, ice[i][4], ice[i]});
    end
    wr(AFE_OFF_CURRENT_SOURCE_CONTROL, 32'h0000_0000);
    check("off", {26'h0, bo_neg, bo_pos, exc1, exc2}, 32'h0000_0000);
    for (int j = 0; j < 6; j++) begin
      if (j % 3 == 0) wr(AFE_OFF_PRIMARY, j == 0 ? 32'h0000_0047 : 32'h0000_00C7);
      pulse(0, raw[j]);
      rd_chk("pdata", AFE_OFF_PDATA, 32'(cod[j]));
    end
    pulse(0, 16'h7FFF);
    rd_chk("pdata_fs", AFE_OFF_PDATA, 32'h0000_FFFF);
    check("gain_kept", 32'(gain_sel), 32'h0000_0007);
    pulse(1, 16'h0000);
    rd_chk("adata", AFE_OFF_ADATA, 32'h0000_8000);
    for (int m = 1; m < 4; m++) begin
      ref_mode <= 2'(m);
      repeat (3) @(posedge pclk);
      pulse(0, 16'h1234);
      rd_chk("forced", AFE_OFF_PDATA, 32'h0000_FFFF);
      pulse(1, 16'h1234);
      rd_chk("aforced", AFE_OFF_ADATA, 32'h0000_FFFF);
      rd_chk("nref", AFE_OFF_STATUS, 32'h0000_0001);
      ref_mode <= 2'h0;
      repeat (3) @(posedge pclk);
      check("flag_clear", 32'(flag), 32'h0000_0000);
    end
    cal(0, 1'b0, 2'h0, 16'h1234);
    rd_chk("pofs_cal", AFE_OFF_POFS, 32'h0000_1234);
    cal(0, 1'b1, 2'h1, 16'h2222);
    rd_chk("pgain_kept", AFE_OFF_PGAIN, 32'(AFE_GAIN_RESET));
    rd_chk("primary_cal_error", AFE_OFF_STATUS, 32'h0000_0002);
    cal(0, 1'b1, 2'h0, 16'h2345);
    rd_chk("primary_cal_error_clr", AFE_OFF_STATUS, 32'h0000_0000);
    rd_chk("pgain_cal", AFE_OFF_PGAIN, 32'h0000_2345);
    cal(1, 1'b0, 2'h2, 16'h3333);
    rd_chk("aofs_kept", AFE_OFF_AOFS, 32'(AFE_OFS_RESET));
    rd_chk("aux_cal_error", AFE_OFF_STATUS, 32'h0000_0004);
    cal(1, 1'b1, 2'h0, 16'h3456);
    rd_chk("again_cal", AFE_OFF_AGAIN, 32'h0000_3456);
    rd_chk("aux_cal_error_clr", AFE_OFF_STATUS, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
